// ==== design/host_port_pkg.sv ====
// Constants for the display module host port: cycle kinds, timing, modes.
// Assumes a single 200 MHz clock; all host pins are synchronous to it.
package host_port_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned INIT_TIME_MS  = 500;
    localparam int unsigned INIT_CYCLES   = INIT_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned DATA_W        = 8;

    // ----------------------------------------------------------------
    // Pin levels
    // ----------------------------------------------------------------
    localparam logic MODE_STROBE_PAIR = 1'b0;
    localparam logic MODE_ENABLE_DIR  = 1'b1;
    localparam logic SEL_DATA         = 1'b0;
    localparam logic SEL_CMD_STATUS   = 1'b1;
    localparam logic DIR_WRITE        = 1'b0;
    localparam logic DIR_READ         = 1'b1;

    // ----------------------------------------------------------------
    // Port states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_IDLE = 3'h2,
        ST_BUSY = 3'h4
    } port_state_e;

endpackage

// ==== design/cycle_if.sv ====
// Interface carrying decoded host cycles from the pin decoder to the port core.
// Assumes one clock domain; all members are single-cycle pulses or levels.
`timescale 1ns/1ps
`default_nettype none
interface cycle_if;
    logic       wr_pulse;  // One-cycle pulse at the start of a write.
    logic       rd_active; // Level while a read cycle is in progress.
    logic       sel;       // Command/data select sampled with the cycle.
    logic [7:0] wdata;     // Byte captured on a write.

    modport decoder (output wr_pulse, rd_active, sel, wdata);
    modport core    (input  wr_pulse, rd_active, sel, wdata);
endinterface
`default_nettype wire

// ==== design/cycle_decoder.sv ====
// Decodes the raw host strobes into write pulses and read levels.
// Assumes pins are already synchronous to clk and the mode strap is stable.
`timescale 1ns/1ps
`default_nettype none
module cycle_decoder
    import host_port_pkg::*;
(
    input  wire logic       clk,             // System clock.
    input  wire logic       reset_n,         // Synchronous reset, active low.
    input  wire logic       mode,            // Bus convention strap.
    input  wire logic       cs_n,            // Chip select, active low.
    input  wire logic       cmd_data_select, // Command/data select.
    input  wire logic       rd_pin,          // Read strobe or enable.
    input  wire logic       wr_pin,          // Write strobe or direction.
    input  wire logic [7:0] data_in,         // Host data bus input.
    input  wire logic       hold,            // Ignore cycles while set.
    cycle_if.decoder        cyc              // Decoded cycles.
);
    // ----------------------------------------------------------------
    // Strobe decode
    // ----------------------------------------------------------------
    wire sp_wr  = (mode == MODE_STROBE_PAIR) && !wr_pin;
    wire sp_rd  = (mode == MODE_STROBE_PAIR) && !rd_pin && wr_pin;
    wire ed_wr  = (mode == MODE_ENABLE_DIR) && rd_pin && (wr_pin == DIR_WRITE);
    wire ed_rd  = (mode == MODE_ENABLE_DIR) && rd_pin && (wr_pin == DIR_READ);
    wire sel_ok = !cs_n && !hold;
    wire wr_now = sel_ok && (sp_wr || ed_wr);
    wire rd_now = sel_ok && (sp_rd || ed_rd);

    logic wr_last;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_last       <= 1'b0;
            cyc.wr_pulse  <= 1'b0;
            cyc.rd_active <= 1'b0;
            cyc.sel       <= SEL_DATA;
            cyc.wdata     <= 8'h00;
        end else begin
            wr_last       <= wr_now;
            cyc.wr_pulse  <= wr_now && !wr_last;
            cyc.rd_active <= rd_now;
            cyc.sel       <= cmd_data_select;
            if (wr_now && !wr_last) begin
                cyc.wdata <= data_in;
            end
        end
    end

    a_write_single: assert property (@(posedge clk) disable iff (!reset_n)
        cyc.wr_pulse |=> !cyc.wr_pulse) else $error("write pulse longer than one cycle");
endmodule
`default_nettype wire

// ==== design/display_host_port.sv ====
// Host parallel port of the display module: decodes host cycles, holds the
// busy line during power-up initialisation and command work, and drives reads.
// Assumes host pins synchronous to clk and a stable convention strap.
//
// Notes on behaviour
// - In strobe-pair mode a low write pin writes a byte into the device.
// - In enable-plus-direction mode the write pin is high for read, low for write.
// - While reset is low the controller is fully reset.
// - All bytes use one shared eight-bit bus, driven by the device only on reads.
// - An attention output tells the host that controller status changed.
// - The busy line is driven low while the controller is busy.
// - After power-up the device initialises itself for about half a second.
// - Select low means data cycles, high means status read or command write.
// - Cycles are served only while chip select is low.
// - The read pin is a low read strobe or a high enable, by convention.
`timescale 1ns/1ps
`default_nettype none
module display_host_port
    import host_port_pkg::*;
#(
    parameter int unsigned INIT_COUNT = INIT_CYCLES, // Power-up initialisation cycles.
    parameter int unsigned CMD_BUSY   = 4            // Busy cycles after a command.
) (
    input  wire logic       clk,             // System clock, 200 MHz.
    input  wire logic       reset_n,         // Synchronous reset, active low.
    input  wire logic       mode,            // Convention strap, 0 strobe pair.
    input  wire logic       cs_n,            // Chip select, active low.
    input  wire logic       cmd_data_select, // Command/data select.
    input  wire logic       rd_pin,          // Read strobe or enable.
    input  wire logic       wr_pin,          // Write strobe or direction.
    input  wire logic [7:0] data_in,         // Host data bus input.
    output logic      [7:0] data_out,        // Host data bus output.
    output logic            data_oe,         // Data bus output enable.
    output logic            attention,       // Status change indication.
    output logic            busy_n,          // Busy/hold, active low.
    output logic      [7:0] data_byte,       // Last data byte written.
    output logic            data_strobe,     // Pulse on each data write.
    output logic      [7:0] cmd_byte,        // Last command byte written.
    output logic            cmd_strobe       // Pulse on each command write.
);
    // The busy counter and its assertion bound serve at most 255 command cycles.
    if (INIT_COUNT < 1 || CMD_BUSY < 1 || CMD_BUSY > 255) begin : g_bad_param
        $error("display_host_port: bad parameter");
    end

    // ----------------------------------------------------------------
    // Cycle decode
    // ----------------------------------------------------------------
    cycle_if     cyc ();
    port_state_e state;
    port_state_e next_state;
    logic [31:0] count;
    logic [7:0]  status;
    logic [7:0]  next_status;
    logic [7:0]  read_mux;

    // Busy hides cycles from the decoder, so a host that ignores the line
    // loses its cycle rather than corrupting a command in progress.
    wire hold = (state != ST_IDLE);

    cycle_decoder u_dec (
        .clk             (clk),
        .reset_n         (reset_n),
        .mode            (mode),
        .cs_n            (cs_n),
        .cmd_data_select (cmd_data_select),
        .rd_pin          (rd_pin),
        .wr_pin          (wr_pin),
        .data_in         (data_in),
        .hold            (hold),
        .cyc             (cyc)
    );

    wire data_wr = cyc.wr_pulse && (cyc.sel == SEL_DATA);
    wire cmd_wr  = cyc.wr_pulse && (cyc.sel == SEL_CMD_STATUS);

    // ----------------------------------------------------------------
    // State machine
    // ----------------------------------------------------------------
    wire count_done = (count == 32'h0);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_INIT: begin
                if (count_done) next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (cmd_wr) next_state = ST_BUSY;
            end
            ST_BUSY: begin
                if (count_done) next_state = ST_IDLE;
            end
            default: next_state = ST_INIT;
        endcase
    end

    // Status: bit 0 ready, bit 1 command seen, bits 7:2 zero.
    assign next_status = {6'h00, cmd_wr | status[1], next_state == ST_IDLE};
    assign read_mux    = (cyc.sel == SEL_CMD_STATUS) ? status : data_byte;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= ST_INIT;
            count <= INIT_COUNT - 1;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && cmd_wr) begin
                count <= CMD_BUSY - 1;
            end else if (!count_done) begin
                count <= count - 32'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Host-facing outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status      <= 8'h00;
            attention   <= 1'b0;
            busy_n      <= 1'b0;
            data_oe     <= 1'b0;
            data_out    <= 8'h00;
            data_byte   <= 8'h00;
            data_strobe <= 1'b0;
            cmd_byte    <= 8'h00;
            cmd_strobe  <= 1'b0;
        end else begin
            status      <= next_status;
            attention   <= (next_status != status);
            busy_n      <= (next_state == ST_IDLE);
            data_oe     <= cyc.rd_active;
            data_out    <= read_mux;
            data_strobe <= data_wr;
            cmd_strobe  <= cmd_wr;
            if (data_wr) data_byte <= cyc.wdata;
            if (cmd_wr)  cmd_byte  <= cyc.wdata;
        end
    end

    a_busy_matches_state: assert property (@(posedge clk) disable iff (!reset_n)
        busy_n == (state == ST_IDLE)) else $error("busy line disagrees with state");
    a_bus_only_read: assert property (@(posedge clk) disable iff (!reset_n)
        data_oe |-> $past(cyc.rd_active)) else $error("bus driven outside a read");
    a_reset_releases_bus: assert property (@(posedge clk)
        !reset_n |=> !data_oe && !busy_n) else $error("bus or busy wrong after reset");
    a_cmd_makes_busy: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_wr && state == ST_IDLE |=> state == ST_BUSY ##1 !busy_n)
        else $error("command did not raise busy");
    a_cmd_busy_ends: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(state == ST_BUSY) |-> ##[1:255] state == ST_IDLE)
        else $error("busy after command never ended");
    a_attention_on_change: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(status) |-> attention) else $error("status change without attention");
    a_data_write_kind: assert property (@(posedge clk) disable iff (!reset_n)
        data_strobe |-> $past(cyc.sel) == SEL_DATA && !cmd_strobe)
        else $error("data strobe on command cycle");
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
// Host microcontroller model that runs one parallel bus cycle per call.
// Assumes the bench owns the mode strap and reset; pins move just after clk rises.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import host_port_pkg::*;
(
    input  wire logic       clk,      // System clock.
    input  wire logic       mode,     // Bus convention strap.
    input  wire logic       busy_n,   // Device busy, active low.
    input  wire logic       data_oe,  // Device drives the bus.
    input  wire logic [7:0] data_out, // Device bus output.
    output logic            cs_n,     // Chip select, active low.
    output logic            sel,      // Command/data select.
    output logic            rd_pin,   // Read strobe or enable.
    output logic            wr_pin,   // Write strobe or direction.
    output wire logic [7:0] data_in   // Resolved bus level.
);
    logic [7:0] drv;
    logic       own;

    // A released bus shows the inverse of the last byte, so a stale copy never passes.
    assign data_in = data_oe ? data_out : (own ? drv : ~drv);

    initial begin
        cs_n = 1'b1;
        sel = 1'b0;
        rd_pin = 1'b1;
        wr_pin = 1'b1;
        drv = 8'h00;
        own = 1'b0;
    end

    task automatic run(input logic w, input logic s, input logic en, input logic chk,
                       input logic [7:0] b, output logic [7:0] q);
        int n;
        for (n = 0; chk && n < 200 && busy_n !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        cs_n   <= ~en;
        sel    <= s;
        drv    <= b;
        own    <= w;
        rd_pin <= (mode == MODE_STROBE_PAIR) ? w : 1'b1;
        wr_pin <= w ? DIR_WRITE : DIR_READ;
        repeat (4) @(posedge clk);
        q = data_in;
        cs_n   <= 1'b1;
        own    <= 1'b0;
        rd_pin <= ~mode;
        wr_pin <= 1'b1;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== tb/display_module_host_port_bench.sv ====
// Self-checking bench for the display host port with a host model on the bus.
// Assumes a shortened init count and the default command busy count of 4, set at the instance below.
`timescale 1ns/1ps
`default_nettype none
module display_module_host_port_bench
    import host_port_pkg::*;
;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       mode = MODE_STROBE_PAIR;
    logic       cs_n, sel, rd_pin, wr_pin, data_oe, attention, busy_n;
    logic       data_strobe, cmd_strobe;
    logic [7:0] data_out, data_byte, cmd_byte, q;
    wire  [7:0] data_in;
    int         failures = 0, tests_run = 0;
    int         dcnt = 0, ccnt = 0, acnt = 0, blo = 0;

    always #2.5 clk = ~clk;

    display_host_port #(.INIT_COUNT(20), .CMD_BUSY(4)) u_display_host_port (
        .clk(clk), .reset_n(reset_n), .mode(mode), .cs_n(cs_n),
        .cmd_data_select(sel), .rd_pin(rd_pin), .wr_pin(wr_pin), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .attention(attention), .busy_n(busy_n),
        .data_byte(data_byte), .data_strobe(data_strobe), .cmd_byte(cmd_byte),
        .cmd_strobe(cmd_strobe));

    host_model u_host_model (
        .clk(clk), .mode(mode), .busy_n(busy_n), .data_oe(data_oe), .data_out(data_out),
        .cs_n(cs_n), .sel(sel), .rd_pin(rd_pin), .wr_pin(wr_pin), .data_in(data_in));

    always @(posedge clk) begin
        dcnt <= dcnt + int'(data_strobe === 1'b1);
        ccnt <= ccnt + int'(cmd_strobe === 1'b1);
        acnt <= acnt + int'(attention === 1'b1);
        blo  <= blo + int'(busy_n === 1'b0);
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset(input logic m);
        int n;
        int d0;
        @(posedge clk);
        d0 = dcnt;
        reset_n <= 1'b0;
        mode    <= m;
        u_host_model.run(1'b1, SEL_DATA, 1'b1, 1'b0, 8'hee, q);
        repeat (10) @(posedge clk);
        check("strobes in reset", 8'(d0), 8'(dcnt));
        check("oe in reset", 8'h00, {7'h0, data_oe});
        reset_n <= 1'b1;
        for (n = 0; n < 100 && busy_n !== 1'b1; n++) @(posedge clk);
        check("init span ok", 8'h01, {7'h0, n >= 18 && n <= 24});
        $display("test reset done");
    endtask

    task automatic t_deselect;
        int d0;
        d0 = dcnt;
        u_host_model.run(1'b1, SEL_DATA, 1'b0, 1'b1, 8'h77, q);
        repeat (3) @(posedge clk);
        check("deselected strobes", 8'(d0), 8'(dcnt));
        $display("test deselect done");
    endtask

    task automatic t_write(input logic s, input logic [7:0] b);
        int d0, c0, a0, b0;
        d0 = dcnt;
        c0 = ccnt;
        a0 = acnt;
        b0 = blo;
        u_host_model.run(1'b1, s, 1'b1, 1'b1, b, q);
        if (s == SEL_DATA) begin
            check("data strobes", 8'(d0 + 1), 8'(dcnt));
            check("data byte", b, data_byte);
        end else begin
            repeat (8) @(posedge clk);
            check("cmd strobes", 8'(c0 + 1), 8'(ccnt));
            check("cmd byte", b, cmd_byte);
            check("busy after cmd", 8'h01, {7'h0, blo - b0 >= 4});
            check("attention seen", 8'h01, {7'h0, acnt > a0});
        end
        $display("test write done");
    endtask

    task automatic t_read(input logic s, input logic [7:0] exp);
        u_host_model.run(1'b0, s, 1'b1, 1'b1, 8'h00, q);
        check("read byte", exp, q);
        repeat (2) @(posedge clk);
        check("oe after read", 8'h00, {7'h0, data_oe});
        $display("test read done");
    endtask

    initial begin
        t_reset(MODE_STROBE_PAIR);
        t_deselect;
        t_write(SEL_DATA, 8'ha5);
        t_read(SEL_DATA, 8'ha5);
        t_write(SEL_CMD_STATUS, 8'h3c);
        t_read(SEL_CMD_STATUS, 8'h03);
        t_reset(MODE_ENABLE_DIR);
        t_deselect;
        t_write(SEL_DATA, 8'h5a);
        t_read(SEL_DATA, 8'h5a);
        t_write(SEL_CMD_STATUS, 8'h81);
        t_read(SEL_CMD_STATUS, 8'h03);
        print_verdict;
    end

    // The run needs well under a thousand cycles; the limit leaves wide margin.
    initial begin
        #20000;
        failures++;
        print_verdict;
    end
endmodule
`default_nettype wire
